// ==== cprc_core_power_ctl.sv ====
`timescale 1ns/100ps
// Core power control register with retention timers and activity handshake.
// Contract
// - The register is 32 bits; bits 31:10 and 3:1 read zero and ignore writes.
// - Bits 9:7 hold the retention delay used in the wait-for-event state.
// - Bits 6:4 hold the retention delay used in the wait-for-interrupt state.
// - Delay setting 000 disables retention and is the reset value of both fields.
// - Settings 001 to 111 select 2, 8, 32, 64, 128, 256 and 512 counter ticks.
// - Retention readiness is signalled only after the selected ticks have elapsed in wait.
// - Retention entry requests are refused until the selected delay has elapsed.
// - Bit 0 enables a power-down request reported on entry to wait-for-interrupt.
// - Bit 0 at 0 requests no power-down and resets to 0.
// - Bit 0 at 1 requests power-down when wait-for-interrupt is entered.
// - Reads use the encoding op0=11, op1=000, CRn=1111, CRm=0010, op2=111.
// - The register is read-write at levels 1 to 3 and inaccessible at level 0.
// - Writes from level 1 or 2 are allowed or trapped by bit 7 of both aux controls.
module cprc_core_power_ctl
  import cprc_pkg::*;
#(
  parameter int CW = 10
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire cprc_pkg::cprc_req_t sysReq,
  output cprc_pkg::cprc_rsp_t sysRsp,
  input wire logic [31:0] hypAuxControl,
  input wire logic [31:0] monitorAuxControl,
  input wire logic waitForEventState,
  input wire logic waitForInterruptState,
  input wire logic counterTick,
  input wire logic retReq,
  output logic retAccept_q,
  output logic retDeny_q,
  output logic activeRetention_q,
  output logic activePowerdown_q,
  output logic [31:0] powerControl_q
);
  import cprc_pkg::*;

  logic [2:0] evtDelay_q;
  logic [2:0] intDelay_q;
  logic pdnEnable_q;
  logic evtReady;
  logic intReady;
  logic hit;
  logic privOk;
  logic wrTrap;
  logic retReady;

  // Decode the system-register encoding and access level.
  assign hit = sysReq.valid && sysReq.op0 == CPRC_OP0 && sysReq.op1 == CPRC_OP1 &&
               sysReq.crn == CPRC_CRN && sysReq.crm == CPRC_CRM &&
               sysReq.op2 == CPRC_OP2;
  assign privOk = sysReq.level != CPRC_EL0;
  // Level 3 is never trapped; writes from levels 1 and 2 need both aux bits set.
  assign wrTrap = sysReq.write && (sysReq.level == CPRC_EL1 || sysReq.level == CPRC_EL2) &&
                  !(hypAuxControl[CPRC_TRAP_BIT] && monitorAuxControl[CPRC_TRAP_BIT]);

  // Register fields; reserved bits are never stored.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      evtDelay_q <= CPRC_DELAY_RST;
      intDelay_q <= CPRC_DELAY_RST;
      pdnEnable_q <= CPRC_PDN_RST;
    end else if (hit && privOk && sysReq.write && !wrTrap) begin
      evtDelay_q <= sysReq.wdata[CPRC_EVT_LSB +: 3];
      intDelay_q <= sysReq.wdata[CPRC_INT_LSB +: 3];
      pdnEnable_q <= sysReq.wdata[CPRC_PDN_BIT];
    end
  end

  // Register image and access answer, one cycle after the request.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sysRsp <= '0;
      powerControl_q <= '0;
    end else begin
      powerControl_q <= {22'h000000, evtDelay_q, intDelay_q, 3'h0, pdnEnable_q};
      sysRsp.ack <= hit;
      sysRsp.trap <= hit && (!privOk || wrTrap);
      sysRsp.rdata <= (hit && privOk && !sysReq.write) ?
                      {22'h000000, evtDelay_q, intDelay_q, 3'h0, pdnEnable_q} : 32'h00000000;
    end
  end

  // One timer per wait state, counting system-counter ticks.
  cprc_ret_timer #(.CW(CW)) uEvtTimer (
    .core_clk(core_clk),
    .srst(srst),
    .inWait(waitForEventState),
    .tick(counterTick),
    .delaySel(evtDelay_q),
    .readyRet(evtReady)
  );

  cprc_ret_timer #(.CW(CW)) uIntTimer (
    .core_clk(core_clk),
    .srst(srst),
    .inWait(waitForInterruptState),
    .tick(counterTick),
    .delaySel(intDelay_q),
    .readyRet(intReady)
  );

  assign retReady = evtReady || intReady;

  // Activity handshake toward the power controller.
  // Requests that arrive before readiness are refused, never queued for later.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      activeRetention_q <= 1'b0;
      activePowerdown_q <= 1'b0;
      retAccept_q <= 1'b0;
      retDeny_q <= 1'b0;
    end else begin
      activeRetention_q <= retReady;
      activePowerdown_q <= waitForInterruptState && pdnEnable_q;
      retAccept_q <= retReq && retReady;
      retDeny_q <= retReq && !retReady;
    end
  end

  // Readiness stems from a timer that still saw its wait state two edges back.
  // The timer state and the output flop each add one edge of lag.
  property p_ready_needs_wait;
    @(posedge core_clk) disable iff (srst)
      activeRetention_q |-> $past(waitForEventState, 2) || $past(waitForInterruptState, 2);
  endproperty
  a_ready_needs_wait: assert property (p_ready_needs_wait)
    else $error("Retention readiness outside a wait state.");

  // A request before readiness is answered with a refusal only.
  property p_refuse_early;
    @(posedge core_clk) disable iff (srst)
      (retReq && !retReady) |=> retDeny_q && !retAccept_q;
  endproperty
  a_refuse_early: assert property (p_refuse_early)
    else $error("Retention request accepted before delay elapsed.");

  // Both delays at zero keep the retention circuit quiet.
  property p_disabled_never_ready;
    @(posedge core_clk) disable iff (srst)
      (evtDelay_q == 3'h0 && intDelay_q == 3'h0) [*2] |=> !activeRetention_q;
  endproperty
  a_disabled_never_ready: assert property (p_disabled_never_ready)
    else $error("Retention ready with circuit disabled.");

  // Interrupt wait with the enable set raises the power-down request.
  property p_pdn_req;
    @(posedge core_clk) disable iff (srst)
      (waitForInterruptState && pdnEnable_q) |=> activePowerdown_q;
  endproperty
  a_pdn_req: assert property (p_pdn_req)
    else $error("Power-down request missing in interrupt wait.");

  // With the enable clear no power-down is ever requested.
  property p_no_pdn;
    @(posedge core_clk) disable iff (srst)
      !pdnEnable_q |=> !activePowerdown_q;
  endproperty
  a_no_pdn: assert property (p_no_pdn)
    else $error("Power-down requested while disabled.");

  // Reserved bits of the register image always read as zero.
  property p_reserved_zero;
    @(posedge core_clk) disable iff (srst)
      powerControl_q[31:10] == 22'h000000 && powerControl_q[3:1] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved bits not zero.");

  // Unprivileged accesses are answered, but always with a trap.
  property p_el0_trap;
    @(posedge core_clk) disable iff (srst)
      (hit && sysReq.level == CPRC_EL0) |=> sysRsp.trap && sysRsp.ack;
  endproperty
  a_el0_trap: assert property (p_el0_trap)
    else $error("Unprivileged access not trapped.");

  // A trapped write must leave every stored field as it was.
  property p_trapped_write_holds;
    @(posedge core_clk) disable iff (srst)
      (hit && wrTrap) |=> $stable(evtDelay_q) && $stable(intDelay_q) && $stable(pdnEnable_q);
  endproperty
  a_trapped_write_holds: assert property (p_trapped_write_holds)
    else $error("Trapped write changed the register.");

  // A permitted write lands in both delay fields on the next edge.
  property p_write_lands;
    @(posedge core_clk) disable iff (srst)
      (hit && privOk && sysReq.write && !wrTrap) |=>
        evtDelay_q == $past(sysReq.wdata[9:7]) && intDelay_q == $past(sysReq.wdata[6:4]);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("Permitted write did not update delay fields.");

  // Two edges out of both wait states clear readiness.
  property p_leave_clears;
    @(posedge core_clk) disable iff (srst)
      (!waitForEventState && !waitForInterruptState) [*2] |=> !activeRetention_q;
  endproperty
  a_leave_clears: assert property (p_leave_clears)
    else $error("Readiness held after leaving wait.");

  // Leaving interrupt wait and staying out must drop readiness two edges later.
  sequence s_wait_left;
    $fell(waitForInterruptState) && !waitForEventState;
  endsequence

  sequence s_stays_out;
    !waitForInterruptState && !waitForEventState;
  endsequence

  property p_exit_drops_ready;
    @(posedge core_clk) disable iff (srst)
      s_wait_left ##1 s_stays_out |=> !activeRetention_q;
  endproperty
  a_exit_drops_ready: assert property (p_exit_drops_ready)
    else $error("Readiness survived an exit from interrupt wait.");

  // A request that meets readiness is accepted, never refused, on the next edge.
  sequence s_ask_when_ready;
    retReq && retReady;
  endsequence

  property p_accept_ready;
    @(posedge core_clk) disable iff (srst)
      s_ask_when_ready |=> retAccept_q && !retDeny_q;
  endproperty
  a_accept_ready: assert property (p_accept_ready)
    else $error("Ready core did not accept a retention request.");
endmodule

// ==== cprc_core_power_ctl_tb.sv ====
`timescale 1ns/100ps
// Self-checking testbench for the core power retention control block.
module cprc_core_power_ctl_tb;
  import cprc_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  cprc_req_t sysReq = '0;
  cprc_rsp_t sysRsp;
  cprc_rsp_t r;
  logic [31:0] hypAux = 32'h00000000;
  logic [31:0] monAux = 32'h00000000;
  logic wait_for_event_state = 1'b0;
  logic wait_for_interrupt_state = 1'b0;
  logic counterTick = 1'b0;
  logic askEarly = 1'b0;
  logic retReq, retAccept_q, retDeny_q, activeRetention_q, activePowerdown_q;
  logic [31:0] powerControl_q;
  logic [15:0] accCnt, denyCnt;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  int denyExp = 0;
  int tk[8] = '{0, 2, 8, 32, 64, 128, 256, 512};

  cprc_core_power_ctl cprc_core_power_ctl_inst (.core_clk(core_clk), .srst(srst),
    .sysReq(sysReq), .sysRsp(sysRsp), .hypAuxControl(hypAux), .monitorAuxControl(monAux),
    .waitForEventState(wait_for_event_state), .waitForInterruptState(wait_for_interrupt_state), .counterTick(counterTick),
    .retReq(retReq), .retAccept_q(retAccept_q), .retDeny_q(retDeny_q),
    .activeRetention_q(activeRetention_q), .activePowerdown_q(activePowerdown_q),
    .powerControl_q(powerControl_q));
  cprc_power_ctl_model cprc_power_ctl_model_inst (.core_clk(core_clk), .srst(srst),
    .activeRetention_q(activeRetention_q), .retAccept_q(retAccept_q),
    .retDeny_q(retDeny_q), .askEarly(askEarly), .retReq(retReq), .accCnt(accCnt),
    .denyCnt(denyCnt));

  // Clock at 250 MHz.
  always #2 core_clk = ~core_clk;

  // A hang is cut short well beyond the roughly 2300 cycles the tests need.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One register access; the answer is caught in the single cycle that it stands.
  task automatic acc(input logic wr, input logic [1:0] lvl, input logic [3:0] crm,
                     input logic [31:0] wd);
    r = '0;
    sysReq = '{1'b1, wr, CPRC_OP0, CPRC_OP1, CPRC_CRN, crm, CPRC_OP2, lvl, wd};
    @(negedge core_clk);
    sysReq.valid = 1'b0;
    repeat (3) begin
      if (sysRsp.ack === 1'b1) r = sysRsp;
      @(negedge core_clk);
    end
  endtask

  // Ticks are spaced two cycles apart so each one lands on its own edge.
  task automatic ticks(input int n);
    repeat (n) begin
      counterTick = 1'b1;
      @(negedge core_clk);
      counterTick = 1'b0;
      @(negedge core_clk);
    end
  endtask

  initial begin
    repeat (16) @(negedge core_clk);
    srst = 1'b0;
    acc(1'b0, 2'h3, CPRC_CRM, 32'h0);
    chk(r.rdata, 32'h00000000);
    acc(1'b1, 2'h3, CPRC_CRM, 32'hFFFFFFFF);
    acc(1'b0, 2'h3, CPRC_CRM, 32'h0);
    chk(r.rdata, 32'h000003F1);
    chk(powerControl_q, 32'h000003F1);
    acc(1'b0, CPRC_EL0, CPRC_CRM, 32'h0);
    chk({31'h0, r.trap}, 32'h1);
    acc(1'b1, CPRC_EL1, CPRC_CRM, 32'h0);
    chk({31'h0, r.trap}, 32'h1);
    hypAux = 32'h00000080;
    monAux = 32'h00000080;
    acc(1'b1, CPRC_EL2, CPRC_CRM, 32'h0);
    chk({31'h0, r.trap}, 32'h0);
    acc(1'b0, CPRC_EL1, CPRC_CRM, 32'h0);
    chk(r.rdata, 32'h00000000);
    acc(1'b0, 2'h3, 4'h8, 32'h0);
    chk({31'h0, r.ack}, 32'h0);
    // Every interrupt delay setting 1 to 7: not ready one tick short, refused then, ready after.
    for (int s = 1; s < 8; s++) begin
      acc(1'b1, 2'h3, CPRC_CRM, 32'(s) << CPRC_INT_LSB);
      wait_for_interrupt_state = 1'b1;
      repeat (2) @(negedge core_clk);
      ticks(tk[s] - 1);
      repeat (4) @(negedge core_clk);
      chk({31'h0, activeRetention_q}, 32'h0);
      askEarly = 1'b1;
      @(negedge core_clk);
      askEarly = 1'b0;
      denyExp++;
      repeat (3) @(negedge core_clk);
      chk({16'h0, denyCnt}, 32'(denyExp));
      ticks(1);
      repeat (4) @(negedge core_clk);
      chk({31'h0, activeRetention_q}, 32'h1);
      wait_for_interrupt_state = 1'b0;
      repeat (4) @(negedge core_clk);
      chk({31'h0, activeRetention_q}, 32'h0);
    end
    chk({16'h0, accCnt}, 32'h00000007);
    acc(1'b1, 2'h3, CPRC_CRM, 32'h00000080);
    wait_for_event_state = 1'b1;
    repeat (2) @(negedge core_clk);
    ticks(2);
    repeat (4) @(negedge core_clk);
    chk({31'h0, activeRetention_q}, 32'h1);
    wait_for_event_state = 1'b0;
    acc(1'b1, 2'h3, CPRC_CRM, 32'h00000001);
    wait_for_interrupt_state = 1'b1;
    ticks(20);
    chk({31'h0, activeRetention_q}, 32'h0);
    chk({31'h0, activePowerdown_q}, 32'h1);
    // A reset in mid-run must bring back the default settings.
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    chk({31'h0, activePowerdown_q}, 32'h0);
    acc(1'b0, 2'h3, CPRC_CRM, 32'h0);
    chk(r.rdata, 32'h00000000);
    wait_for_interrupt_state = 1'b0;
    acc(1'b1, 2'h3, CPRC_CRM, 32'h00000000);
    wait_for_interrupt_state = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({31'h0, activePowerdown_q}, 32'h0);
    give_verdict();
  end
endmodule

// ==== cprc_pkg.sv ====
// Shared constants and types for the core power retention control block.
package cprc_pkg;
  // System-register encoding of the core power control register.
  localparam logic [1:0] CPRC_OP0 = 2'h3;
  localparam logic [2:0] CPRC_OP1 = 3'h0;
  localparam logic [3:0] CPRC_CRN = 4'hF;
  localparam logic [3:0] CPRC_CRM = 4'h2;
  localparam logic [2:0] CPRC_OP2 = 3'h7;
  // Field positions.
  localparam int CPRC_EVT_LSB = 7;
  localparam int CPRC_INT_LSB = 4;
  localparam int CPRC_PDN_BIT = 0;
  localparam int CPRC_TRAP_BIT = 7;
  // Reset values.
  localparam logic [2:0] CPRC_DELAY_RST = 3'h0;
  localparam logic CPRC_PDN_RST = 1'b0;
  // Tick counts for settings 1 to 7; setting 0 disables retention.
  localparam logic [9:0] CPRC_TICKS_1 = 10'h002;
  localparam logic [9:0] CPRC_TICKS_2 = 10'h008;
  localparam logic [9:0] CPRC_TICKS_3 = 10'h020;
  localparam logic [9:0] CPRC_TICKS_4 = 10'h040;
  localparam logic [9:0] CPRC_TICKS_5 = 10'h080;
  localparam logic [9:0] CPRC_TICKS_6 = 10'h100;
  localparam logic [9:0] CPRC_TICKS_7 = 10'h200;
  // Privilege levels.
  localparam logic [1:0] CPRC_EL0 = 2'h0;
  localparam logic [1:0] CPRC_EL1 = 2'h1;
  localparam logic [1:0] CPRC_EL2 = 2'h2;

  // System-register access request.
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    logic [1:0] level;
    logic [31:0] wdata;
  } cprc_req_t;

  // Access answer.
  typedef struct packed {
    logic ack;
    logic trap;
    logic [31:0] rdata;
  } cprc_rsp_t;

  typedef enum logic [1:0] {
    CPRC_RUN = 2'b00,
    CPRC_COUNT = 2'b01,
    CPRC_READY = 2'b10
  } cprc_state_t;
endpackage

// ==== cprc_power_ctl_model.sv ====
`timescale 1ns/100ps
// Behavioural model of the system power controller on the activity handshake.
module cprc_power_ctl_model (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic activeRetention_q,
  input wire logic retAccept_q,
  input wire logic retDeny_q,
  input wire logic askEarly,
  output logic retReq,
  output logic [15:0] accCnt,
  output logic [15:0] denyCnt
);
  logic askedOnce;

  // Asks once per readiness episode, or early when told to.
  // Driving on the rising edge by non-blocking assignment keeps the model clear of
  // the bench, which moves its own inputs on the falling edge.
  always @(posedge core_clk) begin
    if (srst) begin
      retReq <= 1'b0;
      askedOnce <= 1'b0;
    end else begin
      retReq <= askEarly || (activeRetention_q && !askedOnce);
      askedOnce <= activeRetention_q;
    end
  end

  // Counts the answers so the bench can compare them with its own tally.
  always @(posedge core_clk) begin
    if (srst) begin
      accCnt <= 16'h0000;
      denyCnt <= 16'h0000;
    end else begin
      accCnt <= accCnt + {15'h0000, retAccept_q};
      denyCnt <= denyCnt + {15'h0000, retDeny_q};
    end
  end
endmodule

// ==== cprc_ret_timer.sv ====
`timescale 1ns/100ps
// Retention delay timer for one wait state.
module cprc_ret_timer
  import cprc_pkg::*;
#(
  parameter int CW = 10
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic inWait,
  input wire logic tick,
  input wire logic [2:0] delaySel,
  output logic readyRet
);
  import cprc_pkg::*;

  cprc_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] target;

  // Setting to tick count; zero means disabled.
  function automatic logic [CW-1:0] ticksOf(input logic [2:0] s);
    case (s)
      3'h1: ticksOf = CW'(CPRC_TICKS_1);
      3'h2: ticksOf = CW'(CPRC_TICKS_2);
      3'h3: ticksOf = CW'(CPRC_TICKS_3);
      3'h4: ticksOf = CW'(CPRC_TICKS_4);
      3'h5: ticksOf = CW'(CPRC_TICKS_5);
      3'h6: ticksOf = CW'(CPRC_TICKS_6);
      3'h7: ticksOf = CW'(CPRC_TICKS_7);
      default: ticksOf = '0;
    endcase
  endfunction

  assign target = ticksOf(delaySel);

  // Count ticks from wait entry; leaving the wait state drops everything.
  always_ff @(posedge core_clk) begin
    if (srst || !inWait) begin
      state_q <= CPRC_RUN;
      cnt_q <= '0;
    end else begin
      case (state_q)
        CPRC_RUN: begin
          cnt_q <= '0;
          if (delaySel != CPRC_DELAY_RST) begin
            state_q <= CPRC_COUNT;
          end
        end
        CPRC_COUNT: begin
          if (delaySel == CPRC_DELAY_RST) begin
            state_q <= CPRC_RUN;
          end else if (cnt_q >= target) begin
            state_q <= CPRC_READY;
          end else if (tick) begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
        CPRC_READY: begin
          if (delaySel == CPRC_DELAY_RST) begin
            state_q <= CPRC_RUN;
          end
        end
        default: state_q <= CPRC_RUN;
      endcase
    end
  end

  assign readyRet = (state_q == CPRC_READY);
endmodule
